// ---- hpc_pkg.sv ----
// Package for the hibernation power controller: register map, fields, resets, counts.
// Assumes a 32-bit APB slave clocked by pclk at 25 MHz.
package hpc_pkg;
    localparam logic [11:0] ADDR_COUNTER = 12'h000;
    localparam logic [11:0] ADDR_MATCH0 = 12'h004;
    localparam logic [11:0] ADDR_MATCH1 = 12'h008;
    localparam logic [11:0] ADDR_LOAD = 12'h00c;
    localparam logic [11:0] ADDR_CTRL = 12'h010;
    localparam logic [11:0] ADDR_INT_EN = 12'h014;
    localparam logic [11:0] ADDR_INT_RAW = 12'h018;
    localparam logic [11:0] ADDR_INT_CLR = 12'h01c;
    localparam logic [11:0] ADDR_TRIM = 12'h020;
    localparam logic [11:0] ADDR_STATUS = 12'h024;
    localparam logic [11:0] ADDR_DATA_BASE = 12'h030;
    localparam int DATA_WORDS = 64;
    localparam logic [11:0] ADDR_DATA_LAST = 12'h12c;
    // Control register bit positions
    localparam int CTRL_REQ = 0;
    localparam int CTRL_COUNT_EN = 1;
    localparam int CTRL_CLK_SEL = 2;
    localparam int CTRL_PIN_WEN = 3;
    localparam int CTRL_MATCH_WEN = 4;
    localparam int CTRL_LOWBAT_EN = 5;
    localparam int CTRL_VABORT = 6;
    localparam int CTRL_REF_EN = 7;
    localparam int CTRL_BITS = 8;
    // Interrupt bit positions
    localparam int IRQ_LOWBAT = 0;
    localparam int IRQ_MATCH0 = 1;
    localparam int IRQ_MATCH1 = 2;
    localparam int IRQ_WAKE = 3;
    localparam int IRQ_BITS = 4;
    localparam logic [CTRL_BITS-1:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] TRIM_RESET = 16'h7fff;
    localparam logic [15:0] PREDIV_NOMINAL = 16'h7fff;
    localparam logic [5:0] TRIM_PERIOD_LAST = 6'h3f;
    localparam logic [6:0] XTAL_DIV_LAST = 7'h7f;
    typedef enum logic [1:0] {
        PWR_ON = 2'b00,
        PWR_OFF = 2'b01,
        PWR_WAKE = 2'b10
    } hpc_pwr_e;
    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
    } hpc_req_s;
endpackage

// ---- hpc_top.sv ----
// Hibernation power controller: regulator control, wake, seconds counter,
// retained store, interrupts, APB slave.
// Assumes ref_osc and xtal_in are sync level inputs toggling well below pclk/2.
`timescale 1ns/100ps
module hpc_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ref_osc,
    input wire logic xtal_in,
    input wire logic wake_n,
    input wire logic low_battery,
    output logic regulator_off_n,
    output logic irq
);
    hpc_pkg::hpc_req_s req;
    hpc_pkg::hpc_pwr_e state_ff;
    hpc_pkg::hpc_pwr_e nxt_state;
    logic [hpc_pkg::CTRL_BITS-1:0] ctrl_ff;
    logic [hpc_pkg::IRQ_BITS-1:0] raw_ff;
    logic [hpc_pkg::IRQ_BITS-1:0] en_ff;
    logic [31:0] counter_ff;
    logic [31:0] match_ff [2];
    logic [15:0] trim_ff;
    logic [15:0] prediv_ff;
    logic [5:0] sec_idx_ff;
    logic [6:0] xdiv_ff;
    logic xtal_d_ff;
    logic osc_d_ff;
    logic tick_ff;
    logic [31:0] store_ff [hpc_pkg::DATA_WORDS];
    logic access;
    logic wr;
    logic [31:0] rd_mux;
    logic bad_addr;
    logic [1:0] hit;
    logic pin_wake;
    logic match_wake;
    logic sec_end;
    logic [hpc_pkg::IRQ_BITS-1:0] set_ev;
    logic [hpc_pkg::IRQ_BITS-1:0] clr_ev;

    function automatic logic in_store(input logic [11:0] a);
        in_store = (a >= hpc_pkg::ADDR_DATA_BASE) && (a <= hpc_pkg::ADDR_DATA_LAST);
    endfunction

    function automatic logic [5:0] store_idx(input logic [11:0] a);
        logic [11:0] off;
        off = a - hpc_pkg::ADDR_DATA_BASE;
        store_idx = off[7:2];
    endfunction

    assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
    assign access = psel && penable && pready;
    assign wr = access && req.write;

    // Reference tick: oscillator edge or crystal divided by 128
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xtal_d_ff <= 1'b0;
            osc_d_ff <= 1'b0;
            xdiv_ff <= 7'h00;
            tick_ff <= 1'b0;
        end
        else
        begin
            xtal_d_ff <= xtal_in;
            osc_d_ff <= ref_osc;
            tick_ff <= 1'b0;
            if (!ctrl_ff[hpc_pkg::CTRL_REF_EN])
            begin
                xdiv_ff <= 7'h00;
            end
            else if (ctrl_ff[hpc_pkg::CTRL_CLK_SEL])
            begin
                tick_ff <= ref_osc && !osc_d_ff;
            end
            else if (xtal_in && !xtal_d_ff)
            begin
                xdiv_ff <= xdiv_ff + 7'h01;
                tick_ff <= (xdiv_ff == hpc_pkg::XTAL_DIV_LAST);
            end
        end
    end

    assign sec_end = tick_ff && (prediv_ff == 16'h0000);

    // Predivider and seconds counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prediv_ff <= hpc_pkg::PREDIV_NOMINAL;
            sec_idx_ff <= 6'h00;
            counter_ff <= 32'h0000_0000;
        end
        else
        begin
            if (wr && req.addr == hpc_pkg::ADDR_LOAD)
            begin
                counter_ff <= req.wdata;
                prediv_ff <= hpc_pkg::PREDIV_NOMINAL;
            end
            else if (ctrl_ff[hpc_pkg::CTRL_COUNT_EN] && tick_ff)
            begin
                if (sec_end)
                begin
                    counter_ff <= counter_ff + 32'h0000_0001;
                    sec_idx_ff <= sec_idx_ff + 6'h01;
                    if (sec_idx_ff == hpc_pkg::TRIM_PERIOD_LAST - 6'h01)
                    begin
                        prediv_ff <= trim_ff;
                    end
                    else
                    begin
                        prediv_ff <= hpc_pkg::PREDIV_NOMINAL;
                    end
                end
                else
                begin
                    prediv_ff <= prediv_ff - 16'h0001;
                end
            end
        end
    end

    // Match compare, one per match register
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_match
            assign hit[gi] = ctrl_ff[hpc_pkg::CTRL_COUNT_EN] && (counter_ff == match_ff[gi]);
        end
    endgenerate

    assign pin_wake = ctrl_ff[hpc_pkg::CTRL_PIN_WEN] && !wake_n;
    assign match_wake = ctrl_ff[hpc_pkg::CTRL_MATCH_WEN] && (|hit);

    // Power state machine
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            hpc_pkg::PWR_ON:
            begin
                if (ctrl_ff[hpc_pkg::CTRL_REQ] &&
                    !(ctrl_ff[hpc_pkg::CTRL_VABORT] && ctrl_ff[hpc_pkg::CTRL_LOWBAT_EN]
                      && low_battery))
                begin
                    nxt_state = hpc_pkg::PWR_OFF;
                end
            end
            hpc_pkg::PWR_OFF:
            begin
                if (pin_wake || match_wake)
                begin
                    nxt_state = hpc_pkg::PWR_WAKE;
                end
            end
            hpc_pkg::PWR_WAKE:
            begin
                nxt_state = hpc_pkg::PWR_ON;
            end
            default:
            begin
                nxt_state = hpc_pkg::PWR_ON;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= hpc_pkg::PWR_ON;
            regulator_off_n <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            regulator_off_n <= (nxt_state != hpc_pkg::PWR_OFF);
        end
    end

    // Control, match, trim registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= hpc_pkg::CTRL_RESET;
            match_ff[0] <= 32'hffff_ffff;
            match_ff[1] <= 32'hffff_ffff;
            trim_ff <= hpc_pkg::TRIM_RESET;
            en_ff <= 4'h0;
        end
        else
        begin
            if (state_ff == hpc_pkg::PWR_WAKE)
            begin
                ctrl_ff[hpc_pkg::CTRL_REQ] <= 1'b0;
            end
            else if (state_ff == hpc_pkg::PWR_ON && ctrl_ff[hpc_pkg::CTRL_REQ] &&
                     nxt_state == hpc_pkg::PWR_ON)
            begin
                ctrl_ff[hpc_pkg::CTRL_REQ] <= 1'b0;
            end
            if (wr)
            begin
                case (req.addr)
                    hpc_pkg::ADDR_CTRL: ctrl_ff <= req.wdata[hpc_pkg::CTRL_BITS-1:0];
                    hpc_pkg::ADDR_MATCH0: match_ff[0] <= req.wdata;
                    hpc_pkg::ADDR_MATCH1: match_ff[1] <= req.wdata;
                    hpc_pkg::ADDR_TRIM: trim_ff <= req.wdata[15:0];
                    hpc_pkg::ADDR_INT_EN: en_ff <= req.wdata[hpc_pkg::IRQ_BITS-1:0];
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    // Sticky interrupt status; set wins over clear
    assign set_ev = {pin_wake && state_ff == hpc_pkg::PWR_OFF, hit[1], hit[0],
                     ctrl_ff[hpc_pkg::CTRL_LOWBAT_EN] && low_battery};
    assign clr_ev = (wr && req.addr == hpc_pkg::ADDR_INT_CLR) ?
                    req.wdata[hpc_pkg::IRQ_BITS-1:0] : 4'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            raw_ff <= 4'h0;
            irq <= 1'b0;
        end
        else
        begin
            raw_ff <= (raw_ff & ~clr_ev) | set_ev;
            irq <= |(((raw_ff & ~clr_ev) | set_ev) & en_ff);
        end
    end

    // Retained word store
    always_ff @(posedge pclk)
    begin
        if (wr && in_store(req.addr))
        begin
            store_ff[store_idx(req.addr)] <= req.wdata;
        end
    end

    // APB read decode
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        bad_addr = 1'b0;
        if (in_store(req.addr))
        begin
            rd_mux = store_ff[store_idx(req.addr)];
        end
        else
        begin
            case (req.addr)
                hpc_pkg::ADDR_COUNTER: rd_mux = counter_ff;
                hpc_pkg::ADDR_MATCH0: rd_mux = match_ff[0];
                hpc_pkg::ADDR_MATCH1: rd_mux = match_ff[1];
                hpc_pkg::ADDR_LOAD: rd_mux = 32'h0000_0000;
                hpc_pkg::ADDR_CTRL: rd_mux = {24'h00_0000, ctrl_ff};
                hpc_pkg::ADDR_INT_EN: rd_mux = {28'h000_0000, en_ff};
                hpc_pkg::ADDR_INT_RAW: rd_mux = {28'h000_0000, raw_ff};
                hpc_pkg::ADDR_INT_CLR: rd_mux = 32'h0000_0000;
                hpc_pkg::ADDR_TRIM: rd_mux = {16'h0000, trim_ff};
                hpc_pkg::ADDR_STATUS: rd_mux = {30'h0000_0000, low_battery, state_ff == hpc_pkg::PWR_OFF};
                default: bad_addr = 1'b1;
            endcase
        end
    end

    // No wait state: pready rises at the edge that starts the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && bad_addr;
            if (psel && !penable && !req.write)
            begin
                prdata <= rd_mux;
            end
        end
    end
endmodule

// ---- hpc_checker.sv ----
// Checker for the hibernation power controller, ports of hpc_top only.
// Assumes one pclk domain with presetn as asynchronous active-low reset.
`timescale 1ns/100ps
module hpc_checker
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic low_battery,
    input wire logic regulator_off_n,
    input wire logic irq
);
    logic wr_req;
    assign wr_req = psel && penable && pready && pwrite && paddr == hpc_pkg::ADDR_CTRL
        && pwdata[hpc_pkg::CTRL_REQ];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    property p_setup_ready;
        s_setup |=> pready;
    endproperty
    a_setup_ready: assert property (p_setup_ready) else $error("pready missing after setup");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    property p_idle_ready;
        !psel |=> !pready;
    endproperty
    a_idle_ready: assert property (p_idle_ready) else $error("pready without select");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_unmapped;
        s_setup ##0 (paddr > hpc_pkg::ADDR_DATA_LAST) |=> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_store_ok;
        s_setup ##0 (paddr >= hpc_pkg::ADDR_DATA_BASE && paddr <= hpc_pkg::ADDR_DATA_LAST)
            |=> !pslverr;
    endproperty
    a_store_ok: assert property (p_store_ok) else $error("store access refused");
    property p_wo_read;
        s_access ##0 (!pwrite && (paddr == hpc_pkg::ADDR_LOAD || paddr == hpc_pkg::ADDR_INT_CLR))
            |-> prdata == 32'h0;
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("write-only register read nonzero");
    property p_fall_cause;
        $fell(regulator_off_n) |-> $past(wr_req) || $past(wr_req, 2);
    endproperty
    a_fall_cause: assert property (p_fall_cause) else $error("power removed unrequested");
    property p_refuse;
        wr_req && regulator_off_n && low_battery && pwdata[hpc_pkg::CTRL_LOWBAT_EN]
            && pwdata[hpc_pkg::CTRL_VABORT] |=> regulator_off_n [*3];
    endproperty
    a_refuse: assert property (p_refuse) else $error("hibernated on low battery");
    property p_irq_off;
        s_access ##0 (pwrite && paddr == hpc_pkg::ADDR_INT_EN && pwdata == 32'h0) |=> ##1 !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq high with all disabled");
endmodule
bind hpc_top hpc_checker hpc_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .low_battery(low_battery),
    .regulator_off_n(regulator_off_n), .irq(irq));

// ---- hpc_partner.sv ----
// External regulator and wake source facing hpc_top.
// Assumes the bench commands the wake line; the line has a weak pull-up.
`timescale 1ns/100ps
module hpc_partner
(
    input wire logic regulator_off_n,
    input wire logic wake_cmd,
    output logic wake_n,
    output logic powered
);
    // Released line idles high through the pull-up
    assign wake_n = wake_cmd ? 1'h0 : 1'h1;
    // Regulator enable follows the control line
    assign powered = regulator_off_n;
endmodule

// ---- hpc_top_bench.sv ----
// Self-checking bench for hpc_top over APB with regulator partner.
// Assumes a 40 ns pclk and a zero-wait-state APB slave.
`timescale 1ns/100ps
module hpc_top_bench;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic ref_osc = 1'h0;
    logic xtal_in = 1'h0;
    logic low_battery = 1'h0;
    logic wake_cmd = 1'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wake_n;
    logic regulator_off_n;
    logic irq;
    logic powered;
    logic [31:0] rd;
    logic er;
    int err_count = 0;
    int total_checks = 0;
    always #20 pclk = ~pclk;
    always @(posedge pclk)
    begin
        ref_osc <= ~ref_osc;
        xtal_in <= ~xtal_in;
    end
    hpc_top hpc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_osc(ref_osc), .xtal_in(xtal_in), .wake_n(wake_n),
        .low_battery(low_battery), .regulator_off_n(regulator_off_n), .irq(irq));
    hpc_partner hpc_partner_i (.regulator_off_n(regulator_off_n), .wake_cmd(wake_cmd),
        .wake_n(wake_n), .powered(powered));
    task end_sim();
        if (err_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        // Hold the request until pready is sampled high
        while (pready !== 1'h1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] exp, input logic ex_err);
        apb(1'h0, a, 32'h0);
        check(rd, exp);
        check({31'h0, er}, {31'h0, ex_err});
    endtask
    task t_reset();
        check({30'h0, powered, irq}, 32'h2);
        rchk(hpc_pkg::ADDR_TRIM, 32'h7fff, 1'h0);
        rchk(hpc_pkg::ADDR_MATCH0, 32'hffffffff, 1'h0);
        rchk(hpc_pkg::ADDR_CTRL, 32'h0, 1'h0);
        rchk(hpc_pkg::ADDR_LOAD, 32'h0, 1'h0);
        rchk(12'h130, 32'h0, 1'h1);
    endtask
    task t_store();
        apb(1'h1, hpc_pkg::ADDR_DATA_BASE, 32'h5a5a0001);
        apb(1'h1, hpc_pkg::ADDR_DATA_LAST, 32'ha5a5003f);
        apb(1'h1, 12'h130, 32'h1234);
        check({31'h0, er}, 32'h1);
        // Words survive a reset pulse
        presetn <= 1'h0;
        cyc(2);
        presetn <= 1'h1;
        cyc(1);
        check({31'h0, powered}, 32'h1);
        rchk(hpc_pkg::ADDR_DATA_BASE, 32'h5a5a0001, 1'h0);
        rchk(hpc_pkg::ADDR_DATA_LAST, 32'ha5a5003f, 1'h0);
    endtask
    task t_pin_wake();
        apb(1'h1, hpc_pkg::ADDR_INT_EN, 32'h1 << hpc_pkg::IRQ_WAKE);
        // Match wake source chosen in the same write as the request; pin wake left disabled
        apb(1'h1, hpc_pkg::ADDR_CTRL, (32'h1 << hpc_pkg::CTRL_MATCH_WEN) | 32'h1);
        cyc(3);
        check({31'h0, powered}, 32'h0);
        wake_cmd <= 1'h1;
        cyc(5);
        check({31'h0, powered}, 32'h0);
        wake_cmd <= 1'h0;
        apb(1'h1, hpc_pkg::ADDR_CTRL, (32'h1 << hpc_pkg::CTRL_PIN_WEN) | 32'h1);
        apb(1'h1, hpc_pkg::ADDR_INT_CLR, 32'hf);
        cyc(2);
        wake_cmd <= 1'h1;
        cyc(5);
        check({31'h0, powered}, 32'h1);
        wake_cmd <= 1'h0;
        rchk(hpc_pkg::ADDR_INT_RAW, 32'h1 << hpc_pkg::IRQ_WAKE, 1'h0);
        check({31'h0, irq}, 32'h1);
        apb(1'h1, hpc_pkg::ADDR_INT_CLR, 32'h1 << hpc_pkg::IRQ_WAKE);
        cyc(3);
        check({31'h0, irq}, 32'h0);
        apb(1'h1, hpc_pkg::ADDR_INT_EN, 32'h0);
    endtask
    task t_lowbat();
        low_battery <= 1'h1;
        apb(1'h1, hpc_pkg::ADDR_CTRL, 32'h61);
        cyc(4);
        check({31'h0, powered}, 32'h1);
        rchk(hpc_pkg::ADDR_STATUS, 32'h2, 1'h0);
        check({31'h0, rd[0]}, 32'h0);
        rchk(hpc_pkg::ADDR_INT_RAW, 32'h1 << hpc_pkg::IRQ_LOWBAT, 1'h0);
        low_battery <= 1'h0;
        apb(1'h1, hpc_pkg::ADDR_CTRL, 32'h0);
        apb(1'h1, hpc_pkg::ADDR_INT_CLR, 32'hf);
    endtask
    task t_match();
        apb(1'h1, hpc_pkg::ADDR_TRIM, 32'h7ff0);
        rchk(hpc_pkg::ADDR_TRIM, 32'h7ff0, 1'h0);
        apb(1'h1, hpc_pkg::ADDR_LOAD, 32'h20);
        apb(1'h1, hpc_pkg::ADDR_MATCH0, 32'h20);
        apb(1'h1, hpc_pkg::ADDR_MATCH1, 32'h20);
        apb(1'h1, hpc_pkg::ADDR_INT_EN, 32'h1 << hpc_pkg::IRQ_MATCH0);
        apb(1'h1, hpc_pkg::ADDR_CTRL, 32'h86);
        cyc(4);
        rchk(hpc_pkg::ADDR_COUNTER, 32'h20, 1'h0);
        rchk(hpc_pkg::ADDR_INT_RAW, 32'h6, 1'h0);
        check({31'h0, irq}, 32'h1);
        // Timed wake: match0 one second ahead, match1 out of the way
        apb(1'h1, hpc_pkg::ADDR_MATCH0, 32'h21);
        apb(1'h1, hpc_pkg::ADDR_MATCH1, 32'h0);
        apb(1'h1, hpc_pkg::ADDR_LOAD, 32'h20);
        apb(1'h1, hpc_pkg::ADDR_INT_CLR, 32'hf);
        apb(1'h1, hpc_pkg::ADDR_CTRL, 32'h97);
        cyc(3);
        check({31'h0, powered}, 32'h0);
        // One second is 0x8000 ticks, one tick per two pclk cycles
        cyc(65480);
        check({31'h0, powered}, 32'h0);
        cyc(60);
        check({31'h0, powered}, 32'h1);
        rchk(hpc_pkg::ADDR_COUNTER, 32'h21, 1'h0);
        rchk(hpc_pkg::ADDR_INT_RAW, 32'h1 << hpc_pkg::IRQ_MATCH0, 1'h0);
        check({31'h0, irq}, 32'h1);
    endtask
    initial
    begin
        #(40 * 80000);
        err_count++;
        end_sim();
    end
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        cyc(1);
        t_reset();
        t_store();
        t_pin_wake();
        t_lowbat();
        t_match();
        end_sim();
    end
endmodule
